// File: src/dgd_top.sv
// Chosen here: the placing of the registers and the APB slave port.
`default_nettype none
`include "dgd_defs.svh"
module dgd_top
  import dgd_pkg::*;
#(
  parameter logic [33:0] MINUTE_CYC = 34'(`DGD_MINUTE_CYC)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  input wire logic [7:0] nv_boot_bri,
  input wire logic [7:0] nv_boot_con,
  input wire logic [`DGD_NUM_OUT-1:0] nv_boot_outs,
  input wire logic nv_ack,
  output dgd_nv_t nv_wr,
  output dgd_text_t text_out,
  output dgd_draw_t draw_out,
  output logic bank_load,
  output dgd_bank_t bank_sel,
  output logic [`DGD_NUM_OUT-1:0] switchable_output,
  output logic lamp_on,
  output logic lamp_is_text,
  output logic [7:0] lamp_level,
  output logic [7:0] contrast
);

  typedef struct packed {
    dgd_state_t st;
    logic [7:0] cmd;
    logic [3:0] cnt;
    logic [3:0] need;
    logic [8:0][7:0] par;
    dgd_bank_t bank;
    logic bank_ld;
    logic lamp;
    logic [7:0] mins;
    logic [33:0] tick;
    logic [7:0] bri;
    logic [7:0] con;
    logic [7:0] bri_sv;
    logic [7:0] con_sv;
    logic [`DGD_NUM_OUT-1:0] outs;
    logic [`DGD_NUM_OUT-1:0] outs_sv;
    logic [1:0] ctrl;
    logic rdy;
    dgd_text_t txt;
    dgd_draw_t drw;
    dgd_nv_t nv;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dgd_regs_t;

  dgd_regs_t s_q;
  dgd_regs_t s_d;
  logic take;
  logic [7:0] p0;
  logic [7:0] p1;
  logic [7:0] p2;
  logic [7:0] p3;

  // Parameter count per command; top bit flags a known command
  function automatic logic [4:0] need_of(input logic [7:0] c);
    unique case (c)
      `DGD_C_SAVE_GLYPH: need_of = 5'h19;
      `DGD_C_MED_PLACE: need_of = 5'h13;
      `DGD_C_HBAR_PLACE: need_of = 5'h14;
      `DGD_C_VBAR_PLACE, `DGD_C_OUT_BOOT: need_of = 5'h12;
      `DGD_C_OUT_ON, `DGD_C_OUT_OFF, `DGD_C_BL_ON, `DGD_C_BRI_SET,
      `DGD_C_BRI_SAVE, `DGD_C_CON_SET, `DGD_C_CON_SAVE: need_of = 5'h11;
      `DGD_C_MED_INIT, `DGD_C_HBAR_INIT, `DGD_C_NBAR_INIT, `DGD_C_WBAR_INIT,
      `DGD_C_BL_OFF: need_of = 5'h10;
      default: need_of = 5'h00;
    endcase
  endfunction : need_of

  // Output number 1..N maps to bit N-1; zero or too large names none
  function automatic logic out_hit(input logic [7:0] num, input int idx);
    out_hit = (32'(num) == idx + 1);
  endfunction : out_hit

  assign take = ce && rx_valid && s_q.rdy;
  assign p0 = s_q.par[0];
  assign p1 = s_q.par[1];
  assign p2 = s_q.par[2];
  assign p3 = s_q.par[3];

  // Next-state logic: APB slave, byte parser, executor, backlight timer
  always_comb begin
    logic [4:0] nd;
    nd = need_of(rx_data);
    s_d = s_q;
    s_d.txt.stb = 1'b0;
    s_d.drw.stb = 1'b0;
    s_d.bank_ld = 1'b0;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;

    // APB: no wait state, answer formed in the setup phase and registered into the access phase
    if (psel && !penable) begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h0000_0000;
      unique case (paddr[3:0])
        `DGD_A_CTRL: s_d.prdata = {30'h0, s_q.ctrl};
        `DGD_A_STATUS: s_d.prdata = {16'h0, 8'(s_q.outs), s_q.lamp, 2'h0,
                                     s_q.bank, (s_q.st == ST_NVWAIT), s_q.rdy};
        `DGD_A_LEVELS: s_d.prdata = {s_q.con_sv, s_q.bri_sv, s_q.con, s_q.bri};
        `DGD_A_TIMER: s_d.prdata = {24'h0, s_q.mins};
        default: s_d.pslverr = 1'b1;
      endcase
      if (paddr[11:4] != 8'h00) begin
        s_d.pslverr = 1'b1;
        s_d.prdata = 32'h0000_0000;
      end
    end
    if (psel && penable && s_q.pready && pwrite && !s_q.pslverr &&
        paddr[3:0] == `DGD_A_CTRL) begin
      s_d.ctrl = pwdata[1:0];
    end

    // Backlight countdown; a zero minute count never expires
    if (s_q.lamp && s_q.mins != 8'h00) begin
      if (s_q.tick == MINUTE_CYC - 34'h1) begin
        s_d.tick = 34'h0;
        s_d.mins = s_q.mins - 8'h01;
        if (s_q.mins == 8'h01) begin
          s_d.lamp = 1'b0;
        end
      end else begin
        s_d.tick = s_q.tick + 34'h1;
      end
    end

    unique case (s_q.st)
      // Pick up saved values once reset has been released
      ST_INIT: begin
        s_d.bri = nv_boot_bri;
        s_d.bri_sv = nv_boot_bri;
        s_d.con = nv_boot_con;
        s_d.con_sv = nv_boot_con;
        s_d.outs = nv_boot_outs;
        s_d.outs_sv = nv_boot_outs;
        s_d.st = ST_IDLE;
      end
      ST_IDLE: begin
        if (take) begin
          if (rx_data == `DGD_PREFIX) begin
            s_d.st = ST_PREFIX;
          end else begin
            s_d.txt.stb = 1'b1;
            s_d.txt.char_code = rx_data;
          end
        end
      end
      ST_PREFIX: begin
        if (take) begin
          s_d.cmd = rx_data;
          s_d.cnt = 4'h0;
          s_d.need = nd[3:0];
          if (!nd[4]) begin
            s_d.st = ST_IDLE;
          end else if (nd[3:0] == 4'h0) begin
            s_d.st = ST_EXEC;
          end else begin
            s_d.st = ST_PARAM;
          end
        end
      end
      // Gather every parameter before acting
      ST_PARAM: begin
        if (take) begin
          s_d.par[s_q.cnt] = rx_data;
          s_d.cnt = s_q.cnt + 4'h1;
          if (s_q.cnt + 4'h1 == s_q.need) begin
            s_d.st = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        s_d.st = ST_IDLE;
        s_d.nv.index = p0;
        unique case (s_q.cmd)
          `DGD_C_SAVE_GLYPH: begin
            if (p0 <= `DGD_GLYPH_MAX) begin
              s_d.nv.req = 1'b1;
              s_d.nv.kind = NV_GLYPH;
              for (int i = 0; i < 8; i++) begin
                s_d.nv.data[i*8 +: 8] = s_q.par[i+1] & `DGD_PIX_MASK;
              end
              s_d.st = ST_NVWAIT;
            end
          end
          `DGD_C_MED_INIT: begin
            s_d.bank = BK_MED;
            s_d.bank_ld = 1'b1;
          end
          `DGD_C_HBAR_INIT: begin
            s_d.bank = BK_HBAR;
            s_d.bank_ld = 1'b1;
          end
          `DGD_C_NBAR_INIT: begin
            s_d.bank = BK_NBAR;
            s_d.bank_ld = 1'b1;
          end
          `DGD_C_WBAR_INIT: begin
            s_d.bank = BK_WBAR;
            s_d.bank_ld = 1'b1;
          end
          `DGD_C_MED_PLACE: begin
            // Out-of-range fields drop the command rather than draw garbage
            if (p0 != 8'h00 && p0 <= `DGD_MED_ROW_MAX && p1 != 8'h00 &&
                p1 <= `DGD_ROW_MAX && p2 <= `DGD_DIGIT_MAX) begin
              s_d.drw = '{stb: 1'b1, kind: DR_MED, row: p0, col: p1, dir: 1'b0,
                          len: 8'h02, digit: p2, bank: s_q.bank};
            end
          end
          `DGD_C_HBAR_PLACE: begin
            if (p0 != 8'h00 && p0 <= `DGD_COL_MAX && p1 != 8'h00 &&
                p1 <= `DGD_ROW_MAX && p2 <= 8'h01 && p3 <= `DGD_HLEN_MAX) begin
              s_d.drw = '{stb: 1'b1, kind: DR_HBAR, col: p0, row: p1, dir: p2[0],
                          len: p3, digit: 8'h00, bank: s_q.bank};
            end
          end
          `DGD_C_VBAR_PLACE: begin
            if (p0 != 8'h00 && p0 <= `DGD_COL_MAX && p1 <= `DGD_VLEN_MAX) begin
              s_d.drw = '{stb: 1'b1, kind: DR_VBAR, col: p0, row: 8'h01, dir: 1'b0,
                          len: p1, digit: 8'h00, bank: s_q.bank};
            end
          end
          `DGD_C_OUT_ON, `DGD_C_OUT_OFF: begin
            for (int i = 0; i < `DGD_NUM_OUT; i++) begin
              if (out_hit(p0, i)) begin
                s_d.outs[i] = (s_q.cmd == `DGD_C_OUT_ON);
              end
            end
          end
          `DGD_C_OUT_BOOT: begin
            if (p1 <= 8'h01 && p0 != 8'h00 && 32'(p0) <= `DGD_NUM_OUT) begin
              for (int i = 0; i < `DGD_NUM_OUT; i++) begin
                if (out_hit(p0, i)) begin
                  s_d.outs_sv[i] = p1[0];
                end
              end
              s_d.nv.req = 1'b1;
              s_d.nv.kind = NV_OUT;
              s_d.nv.data = {56'h0, p1};
              s_d.st = ST_NVWAIT;
            end
          end
          `DGD_C_BL_ON: begin
            s_d.lamp = 1'b1;
            s_d.mins = p0;
            s_d.tick = 34'h0;
          end
          `DGD_C_BL_OFF: begin
            s_d.lamp = 1'b0;
            s_d.mins = 8'h00;
          end
          `DGD_C_BRI_SET: s_d.bri = p0;
          `DGD_C_CON_SET: s_d.con = p0;
          `DGD_C_BRI_SAVE, `DGD_C_CON_SAVE: begin
            if (s_q.cmd == `DGD_C_BRI_SAVE) begin
              s_d.bri = p0;
              s_d.bri_sv = p0;
              s_d.nv.kind = NV_BRI;
            end else begin
              s_d.con = p0;
              s_d.con_sv = p0;
              s_d.nv.kind = NV_CON;
            end
            s_d.nv.req = 1'b1;
            s_d.nv.data = {56'h0, p0};
            s_d.st = ST_NVWAIT;
          end
          default: s_d.st = ST_IDLE;
        endcase
      end
      // Store is slow; the request stands until the store acknowledges
      ST_NVWAIT: begin
        if (nv_ack) begin
          s_d.nv.req = 1'b0;
          s_d.st = ST_IDLE;
        end
      end
    endcase

    // Ready is registered, so it follows the next state; the source keeps
    // any unaccepted byte, which is how nothing is lost during a store
    s_d.rdy = s_q.ctrl[`DGD_CTRL_EN] &&
              (s_d.st == ST_IDLE || s_d.st == ST_PREFIX || s_d.st == ST_PARAM);
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.st <= ST_INIT;
      s_q.bank <= BK_NONE;
      s_q.bri <= `DGD_BRI_RST;
      s_q.con <= `DGD_CON_RST;
      s_q.bri_sv <= `DGD_BRI_RST;
      s_q.con_sv <= `DGD_CON_RST;
      s_q.ctrl <= `DGD_CTRL_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state flip-flops
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign rx_ready = s_q.rdy;
  assign nv_wr = s_q.nv;
  assign text_out = s_q.txt;
  assign draw_out = s_q.drw;
  assign bank_load = s_q.bank_ld;
  assign bank_sel = s_q.bank;
  assign switchable_output = s_q.outs;
  assign lamp_on = s_q.lamp;
  assign lamp_is_text = s_q.ctrl[`DGD_CTRL_INV];
  assign lamp_level = s_q.bri;
  assign contrast = s_q.con;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic ex;
  assign ex = ce && s_q.st == ST_EXEC;

  sequence s_prefix_cmd;
    (s_q.st == ST_PREFIX && take) ##1 (s_q.st == ST_EXEC && ce);
  endsequence

  chk_nv_holdoff: assert property (s_q.nv.req |-> !rx_ready)
    else $error("bytes accepted during store");
  chk_text_pass: assert property (s_q.st == ST_IDLE && take && rx_data != `DGD_PREFIX
    |=> text_out.stb && text_out.char_code == $past(rx_data))
    else $error("text byte not passed on");
  chk_bank_med: assert property (s_prefix_cmd ##0 (s_q.cmd == `DGD_C_MED_INIT)
    |=> bank_load && bank_sel == BK_MED)
    else $error("medium bank not loaded");
  chk_bright_set: assert property (ex && s_q.cmd == `DGD_C_BRI_SET
    |=> lamp_level == $past(p0) && !nv_wr.req)
    else $error("brightness not applied");
  chk_con_save: assert property (ex && s_q.cmd == `DGD_C_CON_SAVE
    |=> contrast == $past(p0) && s_q.con_sv == $past(p0) && nv_wr.req)
    else $error("contrast not saved");
  chk_bl_off: assert property (ex && s_q.cmd == `DGD_C_BL_OFF |=> !lamp_on)
    else $error("backlight still on");
  chk_glyph_mask: assert property (nv_wr.req && nv_wr.kind == NV_GLYPH
    |-> (nv_wr.data & 64'hE0E0_E0E0_E0E0_E0E0) == 64'h0 && nv_wr.index <= 8'h07)
    else $error("glyph row padding not zero");
  chk_hbar_len: assert property (draw_out.stb && draw_out.kind == DR_HBAR
    |-> draw_out.len <= 8'h28 && draw_out.row inside {8'h01, 8'h02})
    else $error("horizontal bar out of range");
  chk_out_on: assert property (ex && s_q.cmd == `DGD_C_OUT_ON && p0 == 8'h01
    |=> switchable_output[0])
    else $error("output not switched on");
  chk_bl_zero: assert property (lamp_on && s_q.mins == 8'h00 |=> lamp_on ||
    $past(ex && s_q.cmd == `DGD_C_BL_OFF))
    else $error("untimed backlight went off");

endmodule : dgd_top
`default_nettype wire

// File: src/dgd_defs.svh
`ifndef DGD_DEFS_SVH
`define DGD_DEFS_SVH
// Command stream framing
`define DGD_PREFIX 8'hFE
`define DGD_C_SAVE_GLYPH 8'hC2
`define DGD_C_MED_INIT 8'h6D
`define DGD_C_MED_PLACE 8'h6F
`define DGD_C_HBAR_INIT 8'h68
`define DGD_C_HBAR_PLACE 8'h7C
`define DGD_C_NBAR_INIT 8'h73
`define DGD_C_WBAR_INIT 8'h76
`define DGD_C_VBAR_PLACE 8'h3D
`define DGD_C_OUT_ON 8'h57
`define DGD_C_OUT_OFF 8'h56
`define DGD_C_OUT_BOOT 8'hC3
`define DGD_C_BL_ON 8'h42
`define DGD_C_BL_OFF 8'h46
`define DGD_C_BRI_SET 8'h99
`define DGD_C_BRI_SAVE 8'h98
`define DGD_C_CON_SET 8'h50
`define DGD_C_CON_SAVE 8'h91
// Parameter limits
`define DGD_GLYPH_MAX 8'h07
`define DGD_ROW_MAX 8'h02
`define DGD_COL_MAX 8'h08
`define DGD_MED_ROW_MAX 8'h08
`define DGD_DIGIT_MAX 8'h09
`define DGD_HLEN_MAX 8'h28
`define DGD_VLEN_MAX 8'h10
`define DGD_NUM_OUT 1
`define DGD_PIX_MASK 8'h1F
// Reset values
`define DGD_BRI_RST 8'hFF
`define DGD_CON_RST 8'h80
// Timing
`define DGD_CLK_HZ 200000000
`define DGD_MINUTE_S 60
`define DGD_MINUTE_CYC (64'(`DGD_MINUTE_S) * 64'(`DGD_CLK_HZ))
// APB map (byte addresses)
`define DGD_A_CTRL 4'h0
`define DGD_A_STATUS 4'h4
`define DGD_A_LEVELS 4'h8
`define DGD_A_TIMER 4'hC
`define DGD_CTRL_INV 0
`define DGD_CTRL_EN 1
`define DGD_CTRL_RST 2'h2
`endif

// File: src/dgd_pkg.sv
`default_nettype none
package dgd_pkg;
  typedef enum logic [5:0] {
    ST_INIT = 6'h01, ST_IDLE = 6'h02, ST_PREFIX = 6'h04,
    ST_PARAM = 6'h08, ST_EXEC = 6'h10, ST_NVWAIT = 6'h20
  } dgd_state_t;
  typedef enum logic [2:0] {
    BK_NONE = 3'h0, BK_MED = 3'h1, BK_HBAR = 3'h2, BK_NBAR = 3'h3, BK_WBAR = 3'h4
  } dgd_bank_t;
  typedef enum logic [1:0] {DR_MED = 2'h0, DR_HBAR = 2'h1, DR_VBAR = 2'h2} dgd_draw_kind_t;
  typedef enum logic [1:0] {NV_GLYPH = 2'h0, NV_OUT = 2'h1, NV_BRI = 2'h2, NV_CON = 2'h3} dgd_nv_kind_t;
  typedef struct packed {
    logic stb;
    dgd_draw_kind_t kind;
    logic [7:0] col;
    logic [7:0] row;
    logic dir;
    logic [7:0] len;
    logic [7:0] digit;
    dgd_bank_t bank;
  } dgd_draw_t;
  typedef struct packed {
    logic req;
    dgd_nv_kind_t kind;
    logic [7:0] index;
    logic [63:0] data;
  } dgd_nv_t;
  typedef struct packed {
    logic stb;
    logic [7:0] char_code;
  } dgd_text_t;
endpackage : dgd_pkg
`default_nettype wire

// File: verif/dgd_host_model.sv
`default_nettype none
`include "dgd_defs.svh"
module dgd_host_model
  import dgd_pkg::*;
#(
  parameter int ACK_DLY = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic rx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire dgd_nv_t nv_wr,
  output logic nv_ack,
  output logic [7:0] nv_boot_bri,
  output logic [7:0] nv_boot_con,
  output logic [`DGD_NUM_OUT-1:0] nv_boot_outs
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] q[$];
  logic take;
  int wait_n;
  assign take = rx_valid && rx_ready && ce;
  // Factory contents of the store before any save
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    nv_ack = 1'b0;
    nv_boot_bri = 8'h5A;
    nv_boot_con = 8'h3C;
    nv_boot_outs = '0;
    wait_n = 0;
  end
  function automatic void push(input logic [7:0] b);
    q.push_back(b);
  endfunction : push
  function automatic logic busy();
    return (q.size() != 0) || rx_valid;
  endfunction : busy
  // Each byte held until taken; an idle line shows inverted data, never the old byte
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_valid <= 1'b0;
    end else if (q.size() != 0 && (!rx_valid || take)) begin
      rx_valid <= 1'b1;
      rx_data <= q.pop_front();
    end else if (take) begin
      rx_valid <= 1'b0;
      rx_data <= ~rx_data;
    end
  end
  // Slow store: acknowledges late, so the decoder must hold off meanwhile
  always @(posedge pclk) begin
    nv_ack <= 1'b0;
    if (nv_wr.req === 1'b1 && !nv_ack) begin
      wait_n <= wait_n + 1;
      if (wait_n == ACK_DLY) begin
        nv_ack <= 1'b1;
        wait_n <= 0;
        if (nv_wr.kind == NV_BRI) nv_boot_bri <= nv_wr.data[7:0];
        if (nv_wr.kind == NV_CON) nv_boot_con <= nv_wr.data[7:0];
        if (nv_wr.kind == NV_OUT) nv_boot_outs[0] <= nv_wr.data[0];
      end
    end
  end
endmodule : dgd_host_model
`default_nettype wire

// File: verif/tb_top.sv
`default_nettype none
module tb_top;
  import dgd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [1:0] n;
    logic [23:0] b;
    logic [2:0] bk;
    logic o;
    logic l;
    logic [7:0] c;
    logic [7:0] v;
  } dgd_row_t;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er;
  logic rx_valid, rx_ready, nv_ack, lamp_on, lamp_is_text;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] rx_data, nv_bri, nv_con, lamp_level, contrast, txt_c;
  logic [0:0] nv_outs, sw_out;
  dgd_nv_t nv_wr, nv_q;
  dgd_text_t text_out;
  dgd_draw_t draw_out, dr_q;
  dgd_bank_t bank_sel;
  int err_total, comparisons, cyc, nv_n, dr_n;
  dgd_row_t rows[15];

  dgd_top #(.MINUTE_CYC(34'h14)) dut_u (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .nv_boot_bri(nv_bri), .nv_boot_con(nv_con),
    .nv_boot_outs(nv_outs), .nv_ack(nv_ack), .nv_wr(nv_wr), .text_out(text_out),
    .draw_out(draw_out), .bank_load(), .bank_sel(bank_sel), .switchable_output(sw_out),
    .lamp_on(lamp_on), .lamp_is_text(lamp_is_text), .lamp_level(lamp_level),
    .contrast(contrast));
  dgd_host_model #(.ACK_DLY(8)) host_u (.pclk(pclk), .presetn(presetn), .ce(ce),
    .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .nv_wr(nv_wr),
    .nv_ack(nv_ack), .nv_boot_bri(nv_bri), .nv_boot_con(nv_con), .nv_boot_outs(nv_outs));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Bytes go out most significant first
  task automatic send(input int n, input logic [95:0] b);
    for (int i = 0; i < n; i++) host_u.push(b[95-8*i -: 8]);
  endtask : send

  // Done when the source is empty, the decoder ready and no store pending
  task automatic wait_idle();
    int k;
    k = 0;
    @(posedge pclk);
    while ((host_u.busy() || rx_ready !== 1'b1 || nv_wr.req === 1'b1) && k < 400) begin
      @(posedge pclk);
      k++;
    end
    if (k == 400) err_total++;
    repeat (2) @(posedge pclk);
  endtask : wait_idle

  // Request held from setup until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50) begin
      @(posedge pclk);
      k++;
    end
    if (k == 50) err_total++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Capture strobes and completed stores; cut a hang short
  always @(posedge pclk) begin
    cyc++;
    if (text_out.stb === 1'b1) txt_c <= text_out.char_code;
    if (draw_out.stb === 1'b1) begin
      dr_q <= draw_out;
      dr_n++;
    end
    if (nv_ack === 1'b1) begin
      nv_q <= nv_wr;
      nv_n++;
    end
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end

  initial begin
    rows = '{
      '{2'h3, 24'hFE9940, 3'h0, 1'b0, 1'b0, 8'h3C, 8'h40},
      '{2'h3, 24'hFE5033, 3'h0, 1'b0, 1'b0, 8'h33, 8'h40},
      '{2'h3, 24'hFE5701, 3'h0, 1'b1, 1'b0, 8'h33, 8'h40},
      '{2'h3, 24'hFE5702, 3'h0, 1'b1, 1'b0, 8'h33, 8'h40},
      '{2'h3, 24'hFE5601, 3'h0, 1'b0, 1'b0, 8'h33, 8'h40},
      '{2'h3, 24'hFE4200, 3'h0, 1'b0, 1'b1, 8'h33, 8'h40},
      '{2'h2, 24'hFE4600, 3'h0, 1'b0, 1'b0, 8'h33, 8'h40},
      '{2'h2, 24'hFE6D00, 3'h1, 1'b0, 1'b0, 8'h33, 8'h40},
      '{2'h2, 24'hFE6800, 3'h2, 1'b0, 1'b0, 8'h33, 8'h40},
      '{2'h2, 24'hFE7300, 3'h3, 1'b0, 1'b0, 8'h33, 8'h40},
      '{2'h2, 24'hFE7600, 3'h4, 1'b0, 1'b0, 8'h33, 8'h40},
      '{2'h3, 24'hFE9877, 3'h4, 1'b0, 1'b0, 8'h33, 8'h77},
      '{2'h3, 24'hFE9122, 3'h4, 1'b0, 1'b0, 8'h22, 8'h77},
      '{2'h3, 24'hFE9900, 3'h4, 1'b0, 1'b0, 8'h22, 8'h00},
      '{2'h3, 24'hFE50FF, 3'h4, 1'b0, 1'b0, 8'hFF, 8'h00}};
    {presetn, ce, psel, penable, pwrite, paddr, pwdata} = '0;
    {err_total, comparisons, cyc, nv_n, dr_n} = '0;
    repeat (12) @(posedge pclk);
    chk({lamp_level, contrast}, {8'hFF, 8'h80});
    presetn <= 1'b1;
    ce <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({lamp_level, contrast}, {8'h5A, 8'h3C});
    $display("reset test done");
    foreach (rows[i]) begin
      send(int'(rows[i].n), {rows[i].b, 72'h0});
      wait_idle();
      chk({bank_sel, sw_out, lamp_on, contrast, lamp_level}, {rows[i].bk, rows[i].o,
        rows[i].l, rows[i].c, rows[i].v});
    end
    $display("row tests done");
    apb(1'b1, 12'h000, 32'h0000_0003);
    chk(lamp_is_text, 1'b1);
    apb(1'b0, 12'h008, 32'h0);
    chk({er, rd}, {1'b0, 32'h2277_FF00});
    apb(1'b0, 12'h010, 32'h0);
    chk({er, rd}, {1'b1, 32'h0});
    $display("register test done");
    // Text right behind a store: must wait, not vanish
    send(11, 96'hFEC207E1E2E3E4E5E6E7E800);
    send(1, 96'h42 << 88);
    wait_idle();
    chk({nv_q.kind, nv_q.index, nv_q.data}, {NV_GLYPH, 8'h07, 64'h0807060504030201});
    chk({txt_c, nv_n}, {8'h42, 32'h3});
    send(11, 96'hFEC208010203040506070800);
    send(1, 96'h07 << 88);
    wait_idle();
    chk({txt_c, nv_n}, {8'h07, 32'h3});
    $display("glyph test done");
    send(6, 96'hFE7C01020128 << 48);
    wait_idle();
    chk({dr_q.kind, dr_q.col, dr_q.row, dr_q.dir, dr_q.len}, {DR_HBAR, 16'h0102, 1'b1, 8'h28});
    send(6, 96'hFE7C08010005 << 48);
    send(6, 96'hFE7C01010029 << 48);
    wait_idle();
    chk({dr_q.col, dr_q.dir, dr_q.len, dr_n}, {8'h08, 1'b0, 8'h05, 32'h2});
    send(4, 96'hFE3D0810 << 64);
    wait_idle();
    chk({dr_q.kind, dr_q.col, dr_q.row, dr_q.len}, {DR_VBAR, 24'h080110});
    send(5, 96'hFE6F080209 << 56);
    wait_idle();
    chk({dr_q.kind, dr_q.row, dr_q.col, dr_q.digit, dr_q.len}, {DR_MED, 32'h08020902});
    $display("draw test done");
    send(4, 96'hFEC30101 << 64);
    send(3, 96'hFE4201 << 72);
    wait_idle();
    chk({nv_q.kind, nv_q.index, nv_q.data[0], lamp_on}, {NV_OUT, 8'h01, 2'h3});
    repeat (25) @(posedge pclk);
    chk(lamp_on, 1'b0);
    $display("timer test done");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({lamp_level, contrast, sw_out}, {16'hFF80, 1'b0});
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({lamp_level, contrast, sw_out}, {16'h7722, 1'b1});
    $display("restart test done");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
